// file: scsi_target_message_handler.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Abort clears this nexus, then bus free
// - Abort leaves other nexus state alone
// - Abort on bare nexus: free, queue kept
// - Abort with nothing queued is no error
// - Abort ends extended contingent allegiance
// - Device reset ends all processes everywhere
// - Abort flushes volatile data, no media writes
// - Command complete sent, then release busy
// - Complete done on ACK negate, ATN false
// - Disconnect announces later reselection
// - Disconnect done on ACK negate, ATN false
// - Busy released within ten microseconds
// - Implicit restore, no explicit message sent
// - Never retry command or status by restore
// - Save pointer before disconnect after data
// - Opcode byte zero, control last, LUN bits
// - Command buffer accepts up to 128 bytes
// - Reserved fields zero (not checked), reserved opcodes refused
// - Every mandatory command is implemented; here the command bytes are only parsed, no command runs
// - First message identify, abort or reset
module scsi_target_message_handler
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Bus pins
   input wire logic atn_pin,
   input wire logic ack_pin,
   input wire logic rst_pin,
   output logic bsy_out,
   output logic bsy_oe,
   // Message out from initiator
   input wire logic msg_out_valid,
   input wire logic [7:0] msg_out_byte,
   input wire logic [2:0] initiator_id,
   // Command bytes
   input wire logic cdb_valid,
   input wire logic [7:0] cdb_byte,
   input wire logic cdb_first,
   input wire logic cdb_last,
   // Core requests
   input wire logic selected,
   input wire logic data_moved,
   input wire logic op_finished,
   input wire logic op_disconnect,
   input wire logic flush_done,
   input wire logic set_eca,
   // Core answers
   output logic msg_in_req,
   output logic [7:0] msg_in_byte,
   output logic msg_out_phase,
   output logic flush_req,
   output logic media_write_inhibit,
   output logic bus_free,
   output logic [7:0] opcode,
   output logic [7:0] control,
   output logic [2:0] cmd_lun,
   output logic [7:0] cdb_len,
   output logic cdb_done,
   output logic cdb_reject,
   output logic [63:0] io_pending,
   output logic [63:0] eca_active
);

   typedef enum logic [3:0]
   {
      ST_IDLE,
      ST_FIRST_MSG,
      ST_CONNECTED,
      ST_SEND_SAVE,
      ST_SEND_EXIT,
      ST_WAIT_ACK,
      ST_FLUSH,
      ST_RELEASE,
      ST_MSG_OUT
   } state_e;

   state_e state;
   state_e next_state;
   logic atn_meta, atn_sync, ack_meta, ack_sync, rst_meta, rst_sync;
   logic ack_prev;
   logic ack_negated;
   logic identified;
   logic [2:0] lun;
   logic [5:0] slot;
   logic moved;
   logic exit_disc;
   logic exit_sent;
   logic exit_now;
   logic [7:0] next_msg;
   logic [10:0] bsy_count;
   logic timeout;
   logic is_abort, is_bdr, is_ident;
   logic abort_go, bdr_go;
   logic clear_nexus, clear_all;
   logic [5:0] unused_slot;

   // =========================================================
   // Pin synchronisers
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         atn_meta <= 1'b0;
         atn_sync <= 1'b0;
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
         ack_prev <= 1'b0;
      end
      else if (clk_en)
      begin
         atn_meta <= atn_pin;
         atn_sync <= atn_meta;
         ack_meta <= ack_pin;
         ack_sync <= ack_meta;
         rst_meta <= rst_pin;
         rst_sync <= rst_meta;
         ack_prev <= ack_sync;
      end
   end

   // =========================================================
   // Decode
   assign ack_negated = ack_prev && !ack_sync;
   assign is_abort = msg_out_byte == scsi_msg_pkg::MSG_ABORT;
   assign is_bdr = msg_out_byte == scsi_msg_pkg::MSG_BUS_DEVICE_RESET;
   assign is_ident = (msg_out_byte & scsi_msg_pkg::MSG_IDENTIFY_MASK) != 8'h00;
   assign abort_go = msg_out_valid && is_abort
      && (state == ST_FIRST_MSG || state == ST_CONNECTED
      || state == ST_MSG_OUT);
   assign bdr_go = (msg_out_valid && is_bdr && state != ST_IDLE) || rst_sync;
   assign slot = {initiator_id, lun};
   // Only an identified nexus is cleared; a bare nexus keeps its queue
   assign clear_nexus = abort_go && identified;
   assign clear_all = bdr_go;
   assign timeout = bsy_count >= 11'(scsi_msg_pkg::BSY_RELEASE_CYC
      - scsi_msg_pkg::BSY_LATENCY_CYC);
   assign exit_now = state == ST_CONNECTED ? op_disconnect : exit_disc;
   assign next_msg = next_state == ST_SEND_SAVE
      ? scsi_msg_pkg::MSG_SAVE_DATA_POINTER
      : (exit_now ? scsi_msg_pkg::MSG_DISCONNECT
      : scsi_msg_pkg::MSG_COMMAND_COMPLETE);

   // =========================================================
   // Next state
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (selected)
               next_state = ST_FIRST_MSG;
         ST_FIRST_MSG:
            if (msg_out_valid)
            begin
               if (is_ident)
                  next_state = ST_CONNECTED;
               else if (is_abort)
                  next_state = ST_RELEASE;
               else
                  next_state = ST_RELEASE;
            end
         ST_CONNECTED:
            if (abort_go)
               next_state = ST_FLUSH;
            else if (op_finished || op_disconnect)
               next_state = (moved && op_disconnect) ? ST_SEND_SAVE
                  : ST_SEND_EXIT;
         ST_SEND_SAVE:
            if (ack_negated)
               next_state = ST_SEND_EXIT;
         ST_SEND_EXIT:
            next_state = ST_WAIT_ACK;
         ST_WAIT_ACK:
            if (ack_negated)
               next_state = atn_sync ? ST_MSG_OUT : ST_RELEASE;
         ST_FLUSH:
            if (flush_done)
               next_state = ST_RELEASE;
         ST_RELEASE:
            next_state = ST_IDLE;
         ST_MSG_OUT:
            if (abort_go)
               next_state = ST_FLUSH;
            else if (msg_out_valid)
               next_state = ST_CONNECTED;
         default:
            next_state = ST_IDLE;
      endcase
      if (bdr_go)
         next_state = ST_RELEASE;
      else if (timeout && (state == ST_WAIT_ACK || state == ST_MSG_OUT)
         && exit_sent)
         next_state = ST_RELEASE;
   end

   // =========================================================
   // State and context
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state <= ST_IDLE;
         identified <= 1'b0;
         lun <= 3'h0;
         moved <= 1'b0;
         exit_disc <= 1'b0;
         exit_sent <= 1'b0;
         bsy_count <= 11'h000;
      end
      else if (clk_en)
      begin
         state <= next_state;
         if (state == ST_FIRST_MSG && msg_out_valid && is_ident)
         begin
            identified <= 1'b1;
            lun <= msg_out_byte[2:0];
         end
         if (state == ST_CONNECTED && (op_finished || op_disconnect))
            exit_disc <= op_disconnect;
         if (state == ST_SEND_SAVE && ack_negated)
            moved <= 1'b0;
         if (data_moved)
            moved <= 1'b1;
         if (state == ST_WAIT_ACK && ack_negated)
            exit_sent <= 1'b1;
         bsy_count <= exit_sent ? bsy_count + 11'h001 : 11'h000;
         if (next_state == ST_IDLE)
         begin
            identified <= 1'b0;
            moved <= 1'b0;
            exit_sent <= 1'b0;
         end
      end
   end

   // =========================================================
   // Outputs
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         bsy_out <= 1'b0;
         msg_in_req <= 1'b0;
         msg_in_byte <= 8'h00;
      end
      else if (clk_en)
      begin
         bsy_out <= next_state != ST_IDLE && next_state != ST_RELEASE;
         msg_in_req <= next_state == ST_SEND_SAVE
            || next_state == ST_SEND_EXIT || next_state == ST_WAIT_ACK;
         if (next_state == ST_SEND_SAVE || next_state == ST_SEND_EXIT)
            msg_in_byte <= next_msg;
      end
   end

   assign bsy_oe = bsy_out;
   assign msg_out_phase = state == ST_MSG_OUT;
   assign flush_req = state == ST_FLUSH;
   assign media_write_inhibit = state == ST_FLUSH;
   assign bus_free = state == ST_IDLE;

   // =========================================================
   // Submodules
   scsi_cdb_check u_cdb
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .cdb_valid(cdb_valid),
      .cdb_byte(cdb_byte),
      .cdb_first(cdb_first),
      .cdb_last(cdb_last),
      .lun_by_identify(identified),
      .identify_lun(lun),
      .opcode(opcode),
      .control(control),
      .cmd_lun(cmd_lun),
      .cdb_len(cdb_len),
      .cdb_done(cdb_done),
      .cdb_reject(cdb_reject)
   );

   scsi_nexus_table u_nexus
   (
      .sys_clk(sys_clk),
      .reset(reset),
      .clk_en(clk_en),
      .add_io(cdb_done && !cdb_reject),
      .finish_io(state == ST_RELEASE && !exit_disc && exit_sent),
      .clear_nexus(clear_nexus),
      .clear_all(clear_all),
      .set_eca(set_eca),
      .slot(slot),
      .active_slot_flags(unused_slot),
      .io_pending(io_pending),
      .eca_active(eca_active)
   );

endmodule : scsi_target_message_handler

// file: scsi_msg_pkg.sv
package scsi_msg_pkg;

   // =========================================================
   // Message codes
   localparam logic [7:0] MSG_COMMAND_COMPLETE = 8'h00;
   localparam logic [7:0] MSG_SAVE_DATA_POINTER = 8'h02;
   localparam logic [7:0] MSG_RESTORE_POINTERS = 8'h03;
   localparam logic [7:0] MSG_DISCONNECT = 8'h04;
   localparam logic [7:0] MSG_ABORT = 8'h06;
   localparam logic [7:0] MSG_BUS_DEVICE_RESET = 8'h0C;
   localparam logic [7:0] MSG_IDENTIFY_MASK = 8'h80;

   // =========================================================
   // Nexus table
   localparam int NUM_LUNS = 8;
   localparam int LUN_W = 3;
   localparam int INIT_W = 3;
   localparam int NUM_INITS = 8;
   localparam int NUM_SLOTS = NUM_INITS * NUM_LUNS;
   localparam int SLOT_W = 6;

   // =========================================================
   // Command layout
   localparam int CDB_MAX = 128;
   localparam int CDB_LEN_W = 8;
   localparam int CDB_IDX_W = 7;
   localparam int CDB_LUN_BYTE = 1;
   localparam int CDB_LUN_HI = 7;
   localparam int CDB_LUN_LO = 5;
   localparam logic [2:0] GROUP_RESERVED_3 = 3'h3;
   localparam logic [2:0] GROUP_RESERVED_4 = 3'h4;

   // =========================================================
   // Timing
   localparam int BSY_RELEASE_US = 10;
   localparam int CLK_MHZ = 100;
   localparam int BSY_RELEASE_CYC = BSY_RELEASE_US * CLK_MHZ;
   // Pin sync and release latency taken off the busy deadline
   localparam int BSY_LATENCY_CYC = 5;
   localparam int BSY_CNT_W = 11;

   // =========================================================
   // Message-in choice after a transfer
   typedef enum logic [1:0]
   {
      EXIT_COMPLETE,
      EXIT_DISCONNECT,
      EXIT_RESTORE
   } exit_kind_e;

endpackage : scsi_msg_pkg

// file: scsi_cdb_check.sv
`timescale 1ns/1ps
module scsi_cdb_check
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Command byte stream
   input wire logic cdb_valid,
   input wire logic [7:0] cdb_byte,
   input wire logic cdb_first,
   input wire logic cdb_last,
   input wire logic lun_by_identify,
   input wire logic [2:0] identify_lun,
   // Results
   output logic [7:0] opcode,
   output logic [7:0] control,
   output logic [2:0] cmd_lun,
   output logic [7:0] cdb_len,
   output logic cdb_done,
   output logic cdb_reject
);

   logic [7:0] count;
   logic [2:0] group;
   logic reserved_op;
   logic too_long;
   logic [7:0] next_count;

   assign group = cdb_byte[7:5];
   assign reserved_op = cdb_first && (group == scsi_msg_pkg::GROUP_RESERVED_3
      || group == scsi_msg_pkg::GROUP_RESERVED_4);
   assign next_count = cdb_first ? 8'h01 : count + 8'h01;
   assign too_long = next_count > 8'(scsi_msg_pkg::CDB_MAX);

   // =========================================================
   // Byte capture
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         count <= 8'h00;
         opcode <= 8'h00;
         control <= 8'h00;
         cmd_lun <= 3'h0;
         cdb_len <= 8'h00;
         cdb_done <= 1'b0;
         cdb_reject <= 1'b0;
      end
      else if (clk_en)
      begin
         cdb_done <= 1'b0;
         if (cdb_valid)
         begin
            count <= next_count;
            if (cdb_first)
            begin
               opcode <= cdb_byte;
               cdb_reject <= reserved_op;
               cmd_lun <= identify_lun;
            end
            else if (too_long)
               cdb_reject <= 1'b1;
            if (!cdb_first && count == 8'(scsi_msg_pkg::CDB_LUN_BYTE)
               && !lun_by_identify)
               cmd_lun <= cdb_byte[scsi_msg_pkg::CDB_LUN_HI:
                  scsi_msg_pkg::CDB_LUN_LO];
            if (cdb_last)
            begin
               control <= cdb_byte;
               cdb_len <= next_count;
               cdb_done <= 1'b1;
            end
         end
      end
   end

endmodule : scsi_cdb_check

// file: scsi_nexus_table.sv
`timescale 1ns/1ps
module scsi_nexus_table
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   // Updates
   input wire logic add_io,
   input wire logic finish_io,
   input wire logic clear_nexus,
   input wire logic clear_all,
   input wire logic set_eca,
   input wire logic [5:0] slot,
   // State
   output logic [5:0] active_slot_flags,
   output logic [63:0] io_pending,
   output logic [63:0] eca_active
);

   // =========================================================
   // Per-nexus state
   genvar i;
   generate
      for (i = 0; i < scsi_msg_pkg::NUM_SLOTS; i++)
      begin : g_slot
         logic hit;
         assign hit = slot == 6'(i);
         always_ff @(posedge sys_clk)
         begin
            if (reset)
            begin
               io_pending[i] <= 1'b0;
               eca_active[i] <= 1'b0;
            end
            else if (clk_en)
            begin
               if (clear_all)
                  io_pending[i] <= 1'b0;
               else if (hit && clear_nexus)
                  io_pending[i] <= 1'b0;
               else if (hit && add_io)
                  io_pending[i] <= 1'b1;
               else if (hit && finish_io)
                  io_pending[i] <= 1'b0;
               if (clear_all || (hit && clear_nexus))
                  eca_active[i] <= 1'b0;
               else if (hit && set_eca)
                  eca_active[i] <= 1'b1;
            end
         end
      end
   endgenerate

   assign active_slot_flags = slot;

endmodule : scsi_nexus_table

// file: scsi_initiator_model.sv
`timescale 1ns/1ps
// ==============
// Initiator answering message-in bytes
module scsi_initiator_model
(
   // Clock
   input wire logic sys_clk,
   // Target side
   input wire logic msg_in_req,
   input wire logic [7:0] msg_in_byte,
   input wire logic selected,
   input wire logic data_moved,
   // Test control
   input wire logic hold_atn,
   input wire logic [3:0] ack_delay,
   // Pins and log
   output logic ack_pin = 1'b0,
   output logic atn_pin = 1'b0,
   output logic [7:0] last_byte = 8'hFF,
   output logic [7:0] saved_ptr = 8'h00
);
   logic [7:0] active_ptr = 8'h00;

   always @(posedge sys_clk)
   begin
      if (selected)
         active_ptr <= saved_ptr;
      else if (data_moved)
         active_ptr <= active_ptr + 8'h01;
   end

   // Byte handshake, ACK released only after the hold
   always
   begin
      @(posedge sys_clk);
      if (msg_in_req)
      begin
         repeat (ack_delay) @(posedge sys_clk);
         atn_pin <= hold_atn;
         ack_pin <= 1'b1;
         last_byte <= msg_in_byte;
         if (msg_in_byte == scsi_msg_pkg::MSG_SAVE_DATA_POINTER)
            saved_ptr <= active_ptr;
         repeat (3) @(posedge sys_clk);
         ack_pin <= 1'b0;
         repeat (6) @(posedge sys_clk);
         atn_pin <= 1'b0;
      end
   end
endmodule : scsi_initiator_model

// file: scsi_msg_sva.sv
`timescale 1ns/1ps
// ==============
// Message handler checks
module scsi_msg_sva
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Watched ports
   input wire logic atn_pin,
   input wire logic ack_pin,
   input wire logic msg_out_valid,
   input wire logic [7:0] msg_out_byte,
   input wire logic selected,
   input wire logic data_moved,
   input wire logic flush_done,
   input wire logic bsy_out,
   input wire logic msg_in_req,
   input wire logic [7:0] msg_in_byte,
   input wire logic msg_out_phase,
   input wire logic flush_req,
   input wire logic media_write_inhibit,
   input wire logic bus_free,
   input wire logic [63:0] io_pending
);
   localparam int BSY_MAX = scsi_msg_pkg::BSY_RELEASE_CYC;
   logic moved;
   logic saved;
   logic first;
   logic [10:0] held;
   wire is_cc = msg_in_byte == scsi_msg_pkg::MSG_COMMAND_COMPLETE;
   wire is_dc = msg_in_byte == scsi_msg_pkg::MSG_DISCONNECT;
   wire is_sv = msg_in_byte == scsi_msg_pkg::MSG_SAVE_DATA_POINTER;
   wire ob_ab = msg_out_byte == scsi_msg_pkg::MSG_ABORT;
   wire ob_rs = msg_out_byte == scsi_msg_pkg::MSG_BUS_DEVICE_RESET;
   wire fell_ok = msg_in_req && !atn_pin;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   always_ff @(posedge sys_clk)
   begin
      if (reset || selected)
      begin
         moved <= 1'b0;
         saved <= 1'b0;
      end
      else
      begin
         moved <= moved | data_moved;
         saved <= saved | (msg_in_req && is_sv);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         first <= 1'b0;
      else if (selected || msg_out_valid)
         first <= selected;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset || selected || !bsy_out)
         held <= 11'h000;
      else if (held != 11'h000
         || ($fell(ack_pin) && msg_in_req && (is_cc || is_dc)))
         held <= held + 11'h001;
   end

   property p_cc_free;
      $fell(ack_pin) && fell_ok && is_cc |-> ##[1:6] bus_free;
   endproperty
   a_cc_free: assert property (p_cc_free) else $error("no bus free");
   property p_dc_free;
      $fell(ack_pin) && fell_ok && is_dc |-> ##[1:6] bus_free;
   endproperty
   a_dc_free: assert property (p_dc_free) else $error("no free");
   property p_atn_out;
      $fell(ack_pin) && atn_pin && msg_in_req |->
         (!bus_free) [*3] ##[0:3] msg_out_phase;
   endproperty
   a_atn_out: assert property (p_atn_out) else $error("no msg out");
   property p_bsy_limit;
      held <= BSY_MAX;
   endproperty
   a_bsy_limit: assert property (p_bsy_limit) else $error("busy held");
   property p_no_restore;
      msg_in_req |-> msg_in_byte != scsi_msg_pkg::MSG_RESTORE_POINTERS;
   endproperty
   a_no_restore: assert property (p_no_restore) else $error("restore");
   property p_save_first;
      msg_in_req && is_dc |-> saved == moved;
   endproperty
   a_save_first: assert property (p_save_first) else $error("save ptr");
   property p_bad_first;
      msg_out_valid && first && !msg_out_byte[7] && !ob_ab && !ob_rs
         |-> ##[1:4] bus_free;
   endproperty
   a_bad_first: assert property (p_bad_first) else $error("bad first");
   property p_dev_reset;
      msg_out_valid && ob_rs |-> ##[1:4] io_pending == 64'h0;
   endproperty
   a_dev_reset: assert property (p_dev_reset) else $error("not reset");
   property p_flush_hold;
      flush_req |-> media_write_inhibit && !bus_free;
   endproperty
   a_flush_hold: assert property (p_flush_hold) else $error("flush");
   property p_abort_free;
      flush_req && flush_done |-> ##[1:4] bus_free;
   endproperty
   a_abort_free: assert property (p_abort_free) else $error("abort");
   property p_bare_abort;
      msg_out_valid && first && ob_ab |=> $stable(io_pending) [*4];
   endproperty
   a_bare_abort: assert property (p_bare_abort) else $error("queue");
endmodule : scsi_msg_sva

bind scsi_target_message_handler scsi_msg_sva i_scsi_msg_sva
(
   .sys_clk, .reset, .atn_pin, .ack_pin, .msg_out_valid, .msg_out_byte,
   .selected, .data_moved, .flush_done, .bsy_out, .msg_in_req,
   .msg_in_byte, .msg_out_phase, .flush_req, .media_write_inhibit,
   .bus_free, .io_pending
);

// file: scsi_target_message_handler_tb.sv
`timescale 1ns/1ps
// ==============
// Message handler bench
module scsi_target_message_handler_tb;
   typedef struct packed
   {
      logic [7:0] op;
      logic [7:0] len;
      logic rej;
   } row_s;
   row_s rows [7] = '{'{8'h08, 8'h06, 1'b0}, '{8'h28, 8'h0A, 1'b0},
      '{8'h60, 8'h06, 1'b1}, '{8'h88, 8'h06, 1'b1},
      '{8'hC0, 8'h0C, 1'b0}, '{8'hE0, 8'h80, 1'b0}, '{8'hE1, 8'h81, 1'b1}};
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic msg_out_valid = 1'b0;
   logic [7:0] msg_out_byte = 8'h00;
   logic [2:0] initiator_id = 3'h0;
   logic cdb_valid = 1'b0;
   logic [7:0] cdb_byte = 8'h00;
   logic cdb_first = 1'b0;
   logic cdb_last = 1'b0;
   logic selected = 1'b0;
   logic data_moved = 1'b0;
   logic op_finished = 1'b0;
   logic op_disconnect = 1'b0;
   logic flush_done = 1'b0;
   logic set_eca = 1'b0;
   logic hold_atn = 1'b0;
   logic [3:0] ack_delay = 4'h0;
   logic atn_pin, ack_pin, bsy_out, msg_in_req, msg_out_phase, flush_req;
   logic media_write_inhibit, bus_free, cdb_reject;
   logic [7:0] msg_in_byte, opcode, control, cdb_len, last_byte, saved_ptr;
   logic [2:0] cmd_lun;
   logic [63:0] io_pending, eca_active;
   int n_fail = 0;
   int tests_run = 0;

   always #5 sys_clk = ~sys_clk;

   scsi_target_message_handler i_scsi_target_message_handler
   (
      .sys_clk, .reset, .clk_en(1'b1), .atn_pin, .ack_pin, .rst_pin(1'b0),
      .bsy_out, .bsy_oe(), .msg_out_valid, .msg_out_byte, .initiator_id,
      .cdb_valid, .cdb_byte, .cdb_first, .cdb_last, .selected, .data_moved,
      .op_finished, .op_disconnect, .flush_done, .set_eca, .msg_in_req,
      .msg_in_byte, .msg_out_phase, .flush_req, .media_write_inhibit,
      .bus_free, .opcode, .control, .cmd_lun, .cdb_len, .cdb_done(),
      .cdb_reject, .io_pending, .eca_active
   );

   scsi_initiator_model i_scsi_initiator_model
   (
      .sys_clk, .msg_in_req, .msg_in_byte, .selected, .data_moved,
      .hold_atn, .ack_delay, .ack_pin, .atn_pin, .last_byte, .saved_ptr
   );

   // ==============
   // Shared tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up

   task automatic pulse_msg(input logic [7:0] b);
      @(posedge sys_clk);
      msg_out_valid <= 1'b1;
      msg_out_byte <= b;
      @(posedge sys_clk);
      msg_out_valid <= 1'b0;
   endtask : pulse_msg

   task automatic connect(input logic [2:0] id, input logic [7:0] b);
      @(posedge sys_clk);
      initiator_id <= id;
      selected <= 1'b1;
      @(posedge sys_clk);
      selected <= 1'b0;
      pulse_msg(b);
   endtask : connect

   task automatic send_cdb(input logic [7:0] op, input logic [7:0] len);
      for (int k = 0; k < len; k++)
      begin
         @(posedge sys_clk);
         cdb_valid <= 1'b1;
         cdb_first <= k == 0;
         cdb_last <= k == len - 1;
         cdb_byte <= k == 0 ? op : k == len - 1 ? 8'h00 : k == 1 ? 8'hA0 : k;
      end
      @(posedge sys_clk);
      cdb_valid <= 1'b0;
   endtask : send_cdb

   task automatic finish(input logic disc);
      @(posedge sys_clk);
      op_finished <= !disc;
      op_disconnect <= disc;
      @(posedge sys_clk);
      op_finished <= 1'b0;
      op_disconnect <= 1'b0;
   endtask : finish

   task automatic wait_free;
      int i;
      for (i = 0; i < 3000 && bus_free !== 1'b1; i++)
         @(posedge sys_clk);
      @(negedge sys_clk);
      check(bus_free, 1'b1);
   endtask : wait_free

   // ==============
   // Sequence
   initial
   begin
      int i;
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      @(negedge sys_clk);
      check({bus_free, bsy_out, msg_in_req, cdb_reject}, 4'h8);
      check(io_pending | eca_active, 64'h0);
      $display("reset values done");
      foreach (rows[r])
      begin
         ack_delay <= r;
         connect(3'h0, 8'h83);
         send_cdb(rows[r].op, rows[r].len);
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk);
         check(cdb_reject, rows[r].rej);
         if (!rows[r].rej)
            check({opcode, control, cdb_len, cmd_lun},
               {rows[r].op, 8'h00, rows[r].len, 3'h3});
         finish(1'b0);
         wait_free;
         check({last_byte, io_pending[3], bsy_out}, 10'h000);
         $display("command row %0d done", r);
      end
      connect(3'h1, 8'h82);
      send_cdb(8'h08, 8'h06);
      repeat (2) @(posedge sys_clk) data_moved <= !data_moved;
      @(posedge sys_clk) data_moved <= 1'b0;
      finish(1'b1);
      wait_free;
      check({last_byte, saved_ptr}, 16'h0401);
      ack_delay <= 4'h8;
      connect(3'h2, 8'h80);
      send_cdb(8'h08, 8'h06);
      @(posedge sys_clk) set_eca <= 1'b1;
      @(posedge sys_clk) set_eca <= 1'b0;
      finish(1'b1);
      wait_free;
      check({last_byte, saved_ptr}, 16'h0401);
      check(io_pending, 64'h10400);
      $display("disconnect done");
      connect(3'h2, 8'h80);
      pulse_msg(scsi_msg_pkg::MSG_ABORT);
      repeat (2) @(negedge sys_clk);
      check({flush_req, media_write_inhibit, bus_free}, 3'h6);
      @(posedge sys_clk) flush_done <= 1'b1;
      @(posedge sys_clk) flush_done <= 1'b0;
      wait_free;
      check(io_pending, 64'h400);
      check(eca_active, 64'h0);
      connect(3'h3, scsi_msg_pkg::MSG_ABORT);
      wait_free;
      check(io_pending, 64'h400);
      connect(3'h3, 8'h03);
      wait_free;
      $display("abort done");
      hold_atn <= 1'b1;
      ack_delay <= 4'h0;
      connect(3'h4, 8'h80);
      finish(1'b0);
      wait (ack_pin === 1'b1);
      wait (ack_pin === 1'b0);
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
      check({msg_out_phase, bus_free}, 2'h2);
      hold_atn <= 1'b0;
      for (i = 5; i < 1100 && bsy_out !== 1'b0; i++)
         @(negedge sys_clk);
      check(i < scsi_msg_pkg::BSY_RELEASE_CYC, 1'b1);
      $display("attention done");
      connect(3'h5, scsi_msg_pkg::MSG_BUS_DEVICE_RESET);
      wait_free;
      check(io_pending, 64'h0);
      $display("device reset done");
      wrap_up;
   end

   initial
   begin
      repeat (30000) @(posedge sys_clk);
      n_fail++;
      wrap_up;
   end
endmodule : scsi_target_message_handler_tb
